/* File: logic/esc_exec_stall.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - no branch issue from an empty slot
// - branch issue waits on busy or fed station
// - started pipelines never stall
// - station may enter and start together
// - simple unit waits while previous still runs
// - hold until all operands ready
// - serialized instruction starts only when oldest
// - no new divide while divide runs
// - shared station, four-stage multiply, divide
// - block multiply that would hit divide result
// - branch: one execute, one finish cycle
// - branch result forwarded during finish stage
// - mispredict in execute, then redirect
// - four finished taken branches block branches
// - buffer update stalls lookups, after redirect except in a tight loop
// - tight loop: bubble, update, then redirect
// - load/store pipeline of three stages
// - six load/store sources in fixed priority
// - replay flushes access and younger, relaunches
// - copy into replay buffer leaving stage zero
// - stage-one replay causes
// - misaligned miss replays both; station waits
module esc_exec_stall (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // branch issue queue
   input wire logic biq_valid,
   output logic biq_issue,
   output logic nothing_to_issue,
   output logic station_occupied_stall,
   // branch unit
   input wire logic bu_ops_ready,
   input wire logic bu_is_branch,
   input wire logic bu_taken,
   input wire logic bu_mispred,
   input wire logic bu_btb_write,
   input wire logic bu_tight_loop,
   input wire logic cq_taken_retire,
   output logic bu_start,
   output logic bu_bf_valid,
   output logic bu_fwd_valid,
   output logic bu_mispredict,
   output logic taken_branch_queue_full_stall,
   // fetch side
   output logic fetch_redirect,
   output logic btb_update,
   output logic fetch_lookup_stall,
   // simple integer units a (bit 0) and b (bit 1)
   input wire logic [1:0] su_issue,
   input wire logic [1:0] su_ops_ready,
   input wire logic [1:0] su_serial,
   input wire logic [1:0] su_oldest,
   input wire logic [1:0][5:0] su_lat,
   output logic [1:0] su_start,
   output logic [1:0] unit_occupied_stall,
   // multiply/divide unit
   input wire logic mdu_issue,
   input wire logic mdu_ops_ready,
   input wire logic mdu_serial,
   input wire logic mdu_oldest,
   input wire logic mdu_is_div,
   input wire logic [5:0] mdu_div_lat,
   output logic mdu_start,
   output logic mdu_result_valid,
   output logic result_bus_collision_stall,
   // load/store unit sources
   input wire logic snoop_req,
   input wire logic loadq_req,
   input wire logic reload_req,
   input wire logic ls_issue,
   input wire logic ls_ops_ready,
   input wire logic ls_misal,
   input wire logic [3:0] ls_tag,
   output logic [5:0] ls_src_sel,
   // load/store replay
   input wire logic [6:0] rpl_cause,
   input wire logic misal_miss,
   input wire logic rpl_clear,
   output logic ls_s1_valid,
   output logic [3:0] ls_s1_tag,
   output logic ls_s2_mis_first,
   output logic ls_flush,
   output logic ls_finish,
   output logic [3:0] ls_finish_tag
);

   localparam int TW = esc_pkg::TAG_W;
   localparam int RBD = esc_pkg::RB_DEPTH;

   typedef struct packed {
      logic bu_rs;
      logic bu_iss;
      logic bf;
      logic bf_tkn;
      logic upd;
      esc_pkg::esc_br_e br;
      logic [2:0] tkn_cnt;
      logic [1:0] su_rs;
      logic mdu_rs;
      logic [3:0] mp;
      logic ls_rs;
      logic mis_pend;
      logic [TW-1:0] mis_tag;
      logic [2:0] sv;
      logic [2:0] sbuf;
      logic [2:0] srb;
      logic [2:0] slast;
      logic [2:0] smis1;
      logic [2:0] smis2;
      logic [2:0][TW-1:0] stag;
      logic [RBD-1:0][TW-1:0] rbtag;
      logic [RBD-1:0] rbmis1;
      logic [RBD-1:0] rbmis2;
      logic [1:0] head;
      logic [1:0] lnch;
      logic [2:0] cnt;
      logic [2:0] left;
      logic rwait;
      logic rrun;
      logic rblock;
   } esc_st_s;

   esc_st_s q;
   esc_st_s d;

   // ****************************************
   // branch issue and branch unit
   // ****************************************
   logic bu_sta;
   logic tq_full;

   // a station already fed last cycle also refuses issue
   assign station_occupied_stall = biq_valid & (q.bu_rs | q.bu_iss);
   assign nothing_to_issue = !biq_valid;
   assign biq_issue = biq_valid & !(q.bu_rs | q.bu_iss);
   assign bu_sta = q.bu_rs | biq_issue;
   // a taken branch in its finish stage already holds a queue entry
   assign tq_full = q.tkn_cnt + {2'h0, q.bf & q.bf_tkn}
      >= esc_pkg::TAKEN_Q_DEPTH;
   assign taken_branch_queue_full_stall = bu_sta & bu_is_branch & tq_full;
   assign bu_start = bu_sta & bu_ops_ready
      & !(bu_is_branch & tq_full);
   // the start cycle is the execute stage
   assign bu_mispredict = bu_start & bu_mispred;
   assign bu_bf_valid = q.bf;
   assign bu_fwd_valid = q.bf;
   assign fetch_redirect = (q.br == esc_pkg::BR_REDIR)
      | (q.br == esc_pkg::BR_TL_REDIR);
   assign btb_update = (q.br == esc_pkg::BR_UPD)
      | (q.br == esc_pkg::BR_TL_UPD);
   // single port: a buffer write costs fetch one lookup
   assign fetch_lookup_stall = btb_update;

   // ****************************************
   // simple integer units and multiply/divide
   // ****************************************
   logic [1:0] su_sta;
   logic [1:0] su_busy;
   logic mdu_sta;
   logic div_busy;
   logic div_clash;
   logic [5:0] div_rem;
   logic [5:0] div_lat;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_su
         esc_busy_ctr u_ctr (
            .core_clk(core_clk),
            .nrst(nrst),
            .start(su_start[gi]),
            .lat(su_lat[gi]),
            .remain(),
            .busy(su_busy[gi])
         );
         assign su_sta[gi] = q.su_rs[gi] | su_issue[gi];
         assign su_start[gi] = su_sta[gi] & !su_busy[gi]
            & su_ops_ready[gi]
            & (!su_serial[gi] | su_oldest[gi]);
         assign unit_occupied_stall[gi] = su_sta[gi] & su_busy[gi];
      end
   endgenerate

   // divide length capped at the longest divide
   assign div_lat = (mdu_div_lat > esc_pkg::DIV_MAX_CYC)
      ? esc_pkg::DIV_MAX_CYC : mdu_div_lat;

   esc_busy_ctr u_div (
      .core_clk(core_clk),
      .nrst(nrst),
      .start(mdu_start & mdu_is_div),
      .lat(div_lat),
      .remain(div_rem),
      .busy(div_busy)
   );

   assign mdu_sta = q.mdu_rs | mdu_issue;
   // a multiply now would finish together with the divide
   assign div_clash = !mdu_is_div & (div_rem == esc_pkg::DIV_CLASH_AT);
   assign result_bus_collision_stall = mdu_sta & div_clash;
   assign mdu_start = mdu_sta & mdu_ops_ready
      & (!mdu_serial | mdu_oldest)
      & !(mdu_is_div & div_busy)
      & !div_clash;
   assign mdu_result_valid = q.mp[3] | (div_rem == esc_pkg::LAST_CYC);

   // ****************************************
   // load/store pipeline and replay
   // ****************************************
   logic rep1;
   logic rep2;
   logic flush;
   logic ret;
   logic app;
   logic rgo;
   logic lgo;
   logic [1:0] tail;
   logic [2:0] cnt_n;

   assign rep1 = q.sv[1] & q.sbuf[1] & (|rpl_cause);
   assign rep2 = q.sv[2] & q.smis1[2] & misal_miss;
   assign flush = rep1 | rep2;
   assign ret = q.sv[2] & q.sbuf[2] & !rep2;
   assign app = q.sv[0] & q.sbuf[0] & !q.srb[0];
   assign tail = q.head + q.cnt[1:0];
   assign cnt_n = q.cnt + {2'h0, app} - {2'h0, ret};
   assign rgo = q.rrun & (q.left != 3'h0);
   assign lgo = (q.ls_rs | ls_issue) & ls_ops_ready & !q.rblock;

   assign ls_flush = flush;
   assign ls_finish = ret;
   assign ls_finish_tag = q.stag[2];
   assign ls_s1_valid = q.sv[1] & q.sbuf[1];
   assign ls_s1_tag = q.stag[1];
   assign ls_s2_mis_first = q.sv[2] & q.smis1[2];

   // fixed priority; nothing launches in a flush cycle
   always_comb begin
      ls_src_sel = 6'h00;
      if (!flush) begin
         if (snoop_req) begin
            ls_src_sel[esc_pkg::SRC_SNOOP] = 1'b1;
         end else if (loadq_req) begin
            ls_src_sel[esc_pkg::SRC_LOADQ] = 1'b1;
         end else if (reload_req) begin
            ls_src_sel[esc_pkg::SRC_RELOAD] = 1'b1;
         end else if (rgo) begin
            ls_src_sel[esc_pkg::SRC_REPLAY] = 1'b1;
         end else if (q.mis_pend) begin
            ls_src_sel[esc_pkg::SRC_MISAL] = 1'b1;
         end else if (lgo) begin
            ls_src_sel[esc_pkg::SRC_STATION] = 1'b1;
         end
      end
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      d = q;
      // branch station, execute and finish stages
      d.bu_iss = biq_issue;
      d.bu_rs = bu_sta & !bu_start;
      d.bf = bu_start;
      d.bf_tkn = bu_start & bu_is_branch & bu_taken;
      // taken-branch queue occupancy
      if ((q.bf & q.bf_tkn) && !(cq_taken_retire && q.tkn_cnt != 3'h0)) begin
         d.tkn_cnt = q.tkn_cnt + 3'h1;
      end else if (!(q.bf & q.bf_tkn) && cq_taken_retire
                   && q.tkn_cnt != 3'h0) begin
         d.tkn_cnt = q.tkn_cnt - 3'h1;
      end
      // redirect sequencer
      case (q.br)
         esc_pkg::BR_IDLE: begin
            if (bu_mispredict) begin
               d.upd = bu_btb_write;
               d.br = bu_tight_loop ? esc_pkg::BR_BUBBLE
                  : esc_pkg::BR_REDIR;
            end
         end
         esc_pkg::BR_REDIR: begin
            d.br = q.upd ? esc_pkg::BR_UPD : esc_pkg::BR_IDLE;
         end
         esc_pkg::BR_BUBBLE: begin
            d.br = esc_pkg::BR_TL_UPD;
         end
         esc_pkg::BR_TL_UPD: begin
            d.br = esc_pkg::BR_TL_REDIR;
         end
         default: begin
            d.br = esc_pkg::BR_IDLE;
         end
      endcase
      // unit stations and the multiply stages
      d.su_rs = su_sta & ~su_start;
      d.mdu_rs = mdu_sta & !mdu_start;
      d.mp = {q.mp[2:0], mdu_start & !mdu_is_div};
      d.ls_rs = (q.ls_rs | ls_issue) & !ls_src_sel[esc_pkg::SRC_STATION];
      // load/store stages advance, or empty on a flush
      d.sv = {q.sv[1:0], |ls_src_sel};
      d.stag[2:1] = q.stag[1:0];
      d.sbuf = {q.sbuf[1:0], 1'b0};
      d.srb = {q.srb[1:0], 1'b0};
      d.slast = {q.slast[1:0], 1'b0};
      d.smis1 = {q.smis1[1:0], 1'b0};
      d.smis2 = {q.smis2[1:0], 1'b0};
      d.stag[0] = '0;
      if (ls_src_sel[esc_pkg::SRC_REPLAY]) begin
         d.stag[0] = q.rbtag[q.lnch];
         d.sbuf[0] = 1'b1;
         d.srb[0] = 1'b1;
         d.slast[0] = q.left == 3'h1;
         d.smis1[0] = q.rbmis1[q.lnch];
         d.smis2[0] = q.rbmis2[q.lnch];
         d.lnch = q.lnch + 2'h1;
         d.left = q.left - 3'h1;
         d.rrun = q.left != 3'h1;
      end else if (ls_src_sel[esc_pkg::SRC_MISAL]) begin
         d.stag[0] = q.mis_tag;
         d.sbuf[0] = 1'b1;
         d.smis2[0] = 1'b1;
         d.mis_pend = 1'b0;
      end else if (ls_src_sel[esc_pkg::SRC_STATION]) begin
         d.stag[0] = ls_tag;
         d.sbuf[0] = 1'b1;
         d.smis1[0] = ls_misal;
      end
      // second half follows a first half unless already buffered
      if (q.sv[0] & q.smis1[0] & (!q.srb[0] | q.slast[0])) begin
         d.mis_pend = 1'b1;
         d.mis_tag = q.stag[0];
      end
      // copy into the buffer on leaving stage zero
      if (app) begin
         d.rbtag[tail] = q.stag[0];
         d.rbmis1[tail] = q.smis1[0];
         d.rbmis2[tail] = q.smis2[0];
      end
      if (ret) begin
         d.head = q.head + 2'h1;
      end
      d.cnt = cnt_n;
      // wait state: release on clear, station held until done
      if (q.rwait && rpl_clear) begin
         d.rwait = 1'b0;
         d.rrun = 1'b1;
      end
      if (q.sv[1] && q.slast[1] && !rep1) begin
         d.rblock = 1'b0;
      end
      // replay: pull the access and all younger ones back
      if (flush) begin
         d.sv = 3'h0;
         d.mis_pend = 1'b0;
         d.lnch = q.head + {1'b0, ret};
         d.left = cnt_n;
         d.rwait = 1'b1;
         d.rrun = 1'b0;
         d.rblock = 1'b1;
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.br <= esc_pkg::BR_RST;
      end else begin
         q <= d;
      end
   end

endmodule : esc_exec_stall
`default_nettype wire

/* File: logic/esc_pkg.sv */
`default_nettype none
package esc_pkg;

   // ****************************************
   // widths and depths
   // ****************************************
   localparam int TAG_W = 4;
   localparam int LAT_W = 6;
   localparam int RB_DEPTH = 4;
   localparam int RPL_CAUSE_W = 7;

   // ****************************************
   // cycle counts
   // ****************************************
   // longest divide
   localparam logic [5:0] DIV_MAX_CYC = 6'h23;
   // depth of the multiply subunit
   localparam logic [5:0] MUL_STAGES = 6'h04;
   // divide countdown value that would meet a multiply started now
   localparam logic [5:0] DIV_CLASH_AT = MUL_STAGES + 6'h01;
   // countdown value in the cycle a unit drives its result
   localparam logic [5:0] LAST_CYC = 6'h01;
   // entries of the taken-branch address queue
   localparam logic [2:0] TAKEN_Q_DEPTH = 3'h4;

   // ****************************************
   // load/store source select bits
   // ****************************************
   localparam int SRC_SNOOP = 0;
   localparam int SRC_LOADQ = 1;
   localparam int SRC_RELOAD = 2;
   localparam int SRC_REPLAY = 3;
   localparam int SRC_MISAL = 4;
   localparam int SRC_STATION = 5;

   // ****************************************
   // branch redirect sequencer
   // ****************************************
   typedef enum logic [5:0] {
      BR_IDLE = 6'h01,
      BR_REDIR = 6'h02,
      BR_UPD = 6'h04,
      BR_BUBBLE = 6'h08,
      BR_TL_UPD = 6'h10,
      BR_TL_REDIR = 6'h20
   } esc_br_e;

   // ****************************************
   // values after reset
   // ****************************************
   localparam esc_br_e BR_RST = BR_IDLE;
   localparam logic [5:0] CTR_RST = 6'h00;

endpackage : esc_pkg
`default_nettype wire

/* File: logic/esc_busy_ctr.sv */
`timescale 1ns/1ps
`default_nettype none
module esc_busy_ctr (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // start of an instruction and its length
   input wire logic start,
   input wire logic [5:0] lat,
   // cycles left and occupancy
   output logic [5:0] remain,
   output logic busy
);

   typedef struct packed {
      logic [5:0] rem;
   } esc_ctr_s;

   esc_ctr_s q;
   esc_ctr_s d;

   // ****************************************
   // countdown
   // ****************************************
   // reload on start, otherwise count down to zero
   always_comb begin
      d = q;
      if (start) begin
         d.rem = lat;
      end else if (q.rem != esc_pkg::CTR_RST) begin
         d.rem = q.rem - 6'h01;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q.rem <= esc_pkg::CTR_RST;
      end else begin
         q <= d;
      end
   end

   // the last cycle frees the unit for a new start
   assign remain = q.rem;
   assign busy = q.rem > esc_pkg::LAST_CYC;

endmodule : esc_busy_ctr
`default_nettype wire

/* File: verif/esc_exec_stall_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module esc_exec_stall_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // branch side
   input wire logic biq_valid,
   input wire logic biq_issue,
   input wire logic bu_is_branch,
   input wire logic bu_start,
   input wire logic bu_bf_valid,
   input wire logic bu_fwd_valid,
   input wire logic bu_mispredict,
   input wire logic bu_tight_loop,
   input wire logic taken_branch_queue_full_stall,
   input wire logic btb_update,
   input wire logic fetch_lookup_stall,
   // execution units
   input wire logic [1:0] su_ops_ready,
   input wire logic [1:0] su_serial,
   input wire logic [1:0] su_oldest,
   input wire logic [1:0][5:0] su_lat,
   input wire logic [1:0] su_start,
   input wire logic mdu_start,
   input wire logic result_bus_collision_stall,
   // load/store
   input wire logic snoop_req,
   input wire logic ls_flush,
   input wire logic [5:0] ls_src_sel,
   input wire logic ls_s1_valid,
   input wire logic [6:0] rpl_cause
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   chk_empty_slot: assert property (!biq_valid |-> !biq_issue)
      else $error("branch issue from an empty slot");
   chk_issue_gap: assert property (biq_issue |=> !biq_issue)
      else $error("branch issue in two adjacent cycles");
   chk_finish_stage: assert property (
      bu_start |=> bu_bf_valid && bu_fwd_valid)
      else $error("branch finish stage missing");
   chk_mispred_exec: assert property (bu_mispredict |-> bu_start)
      else $error("mispredict outside execute stage");
   chk_queue_full: assert property (
      taken_branch_queue_full_stall && bu_is_branch |-> !bu_start)
      else $error("branch started with taken queue full");
   chk_btb_port: assert property (
      btb_update |-> fetch_lookup_stall ##1 !btb_update)
      else $error("buffer update without one lookup stall");
   chk_su_gating: assert property (su_start[1] |-> su_ops_ready[1] &&
      (!su_serial[1] || su_oldest[1]))
      else $error("simple unit started early");
   chk_su_busy: assert property (
      su_start[0] && su_lat[0] == 6'h02 |=> !su_start[0])
      else $error("simple unit restarted while busy");
   chk_mdu_clash: assert property (result_bus_collision_stall |-> !mdu_start)
      else $error("multiply started into divide result slot");
   chk_snoop_first: assert property (
      snoop_req && !ls_flush |-> ls_src_sel == 6'h01)
      else $error("snoop not granted first");
   chk_replay_flush: assert property (
      ls_s1_valid && rpl_cause != 7'h00 |-> ls_flush ##1 !ls_s1_valid)
      else $error("replay cause did not flush");
   // main scenarios reached
   cov_tight: cover property (bu_mispredict && bu_tight_loop);
   cov_flush: cover property (ls_flush);
   cov_clash: cover property (result_bus_collision_stall);
endmodule : esc_exec_stall_chk

bind esc_exec_stall esc_exec_stall_chk u_esc_exec_stall_chk (.*);
`default_nettype wire

/* File: verif/esc_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module esc_partner (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // branch and simple unit activity
   input wire logic bu_start,
   input wire logic bu_taken,
   input wire logic bu_is_branch,
   input wire logic bu_bf_valid,
   input wire logic retire_en,
   input wire logic [1:0] su_serial,
   // completion answers
   output logic cq_taken_retire,
   output logic [1:0] su_oldest
);
   logic tk_q;
   logic [2:0] cnt_q;
   // completion side: retires finished taken branches, one every other
   // cycle at most, so the count never underflows
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tk_q <= 1'b0;
         cnt_q <= 3'h0;
         cq_taken_retire <= 1'b0;
         su_oldest <= 2'h0;
      end else begin
         tk_q <= bu_start & bu_taken & bu_is_branch;
         cq_taken_retire <= retire_en & (cnt_q != 3'h0) & !cq_taken_retire;
         cnt_q <= cnt_q + {2'h0, bu_bf_valid & tk_q}
            - {2'h0, cq_taken_retire};
         su_oldest <= su_serial;
      end
   end
endmodule : esc_partner
`default_nettype wire

/* File: verif/esc_exec_stall_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
   $display("BAD %s exp %0h got %0h", n, e, a); err_count++; end end
module esc_exec_stall_tb;
   // ****************************************
   // signals
   // ****************************************
   logic core_clk, nrst, biq_valid, biq_issue, nothing_to_issue;
   logic station_occupied_stall, bu_ops_ready, bu_is_branch, bu_taken;
   logic bu_mispred, bu_btb_write, bu_tight_loop, cq_taken_retire;
   logic bu_start, bu_bf_valid, bu_fwd_valid, bu_mispredict;
   logic taken_branch_queue_full_stall, fetch_redirect, btb_update;
   logic fetch_lookup_stall, mdu_issue, mdu_ops_ready, mdu_serial;
   logic mdu_oldest, mdu_is_div, mdu_start, mdu_result_valid;
   logic result_bus_collision_stall, snoop_req, loadq_req, reload_req;
   logic ls_issue, ls_ops_ready, ls_misal, misal_miss, rpl_clear;
   logic ls_s1_valid, ls_s2_mis_first, ls_flush, ls_finish, retire_en;
   logic [1:0] su_issue, su_ops_ready, su_serial, su_oldest, su_start;
   logic [1:0] unit_occupied_stall;
   logic [1:0][5:0] su_lat;
   logic [5:0] mdu_div_lat, ls_src_sel;
   logic [3:0] ls_tag, ls_s1_tag, ls_finish_tag, tq;
   logic [6:0] rpl_cause;
   logic [2:0] oth;
   logic [11:0] got;
   logic [3:0] ls_q [$];
   bit mdu_exp [1024];
   int err_count, check_count, seed, cyc_n, su_last, su_lp, div_end;
   int ni, ns, i, m, ix;
   localparam logic [11:0] EXP_SEQ [4] = '{12'h800, 12'h8C0, 12'h0E0,
      12'h0E0};
   assign {reload_req, loadq_req, snoop_req} = oth;

   esc_exec_stall u_esc_exec_stall (.*);
   esc_partner u_esc_partner (.core_clk, .nrst, .bu_start, .bu_taken,
      .bu_is_branch, .bu_bf_valid, .retire_en, .su_serial,
      .cq_taken_retire, .su_oldest);

   // ****************************************
   // clock, verdict and helpers
   // ****************************************
   initial begin
      core_clk = 0;
      forever #12.5 core_clk = ~core_clk;
   end
   task results;
      if (err_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   task timed_out;
      err_count++;
      results();
   endtask : timed_out
   // holds the branch slot, counting issues and starts
   task br_hold(input int n, output int nis, output int nst);
      int k;
      nis = 0;
      nst = 0;
      biq_valid = 1;
      for (k = 0; k < n; k++) begin
         #1 nis += (biq_issue === 1'b1);
         nst += (bu_start === 1'b1);
         @(negedge core_clk);
      end
   endtask : br_hold
   // offers one station access, noting its tag once granted
   task ls_go(input logic [3:0] t);
      int k;
      ls_issue = 1;
      ls_tag = t;
      for (k = 0; k < 50; k++) begin
         #1 if (ls_src_sel === 6'h20) break;
         @(negedge core_clk);
      end
      if (k == 50) timed_out();
      ls_q.push_back(t);
      @(negedge core_clk);
   endtask : ls_go
   // random traffic into both simple units and the multiply/divide unit;
   // a new instruction is offered only once the previous one started
   task unit_run(input int n);
      int k;
      logic g0, gb, gm;
      g0 = 1;
      gb = 1;
      gm = 1;
      for (k = 0; k < n; k++) begin
         @(negedge core_clk);
         su_issue = {gb, g0};
         if (g0) su_lat[0] = 6'(1 + {$random(seed)} % 4);
         if (gb) su_serial[1] = 1'($random(seed));
         su_ops_ready = {gb ? 1'($random(seed)) :
            su_ops_ready[1] | 1'($random(seed)), 1'b1};
         mdu_issue = gm;
         if (gm) mdu_is_div = 1'($random(seed));
         if (gm) mdu_div_lat = 6'(5 + {$random(seed)} % 31);
         mdu_ops_ready = gm ? 1'($random(seed)) :
            mdu_ops_ready | 1'($random(seed));
         #1 g0 = (su_start[0] === 1'b1);
         gb = (su_start[1] === 1'b1);
         gm = (mdu_start === 1'b1);
      end
      @(negedge core_clk);
      su_issue = 2'h0;
      mdu_issue = 0;
   endtask : unit_run

   // ****************************************
   // result watcher
   // ****************************************
   // takes the oldest noted tag whenever an access finishes
   always @(posedge core_clk) begin
      if (nrst) begin
         cyc_n <= cyc_n + 1;
         if (ls_finish === 1'b1) begin
            `CHK("ls_pending", 1'b1, ls_q.size() != 0)
            if (ls_q.size() != 0) tq = ls_q.pop_front();
            `CHK("ls_tag", tq, ls_finish_tag)
         end
         `CHK("mdu_result", mdu_exp[cyc_n % 1024], mdu_result_valid)
         mdu_exp[cyc_n % 1024] = 0;
         if (mdu_start === 1'b1) begin
            ix = (cyc_n + (mdu_is_div ? int'(mdu_div_lat) : 4)) % 1024;
            `CHK("bus_free", 1'b0, mdu_exp[ix])
            mdu_exp[ix] = 1;
         end
         if (mdu_start === 1'b1 && mdu_is_div === 1'b1) begin
            `CHK("div_busy", 1'b1, cyc_n >= div_end)
            div_end <= cyc_n + int'(mdu_div_lat);
         end
         if (su_start[0] === 1'b1) begin
            if (su_last >= 0) `CHK("su_gap", su_lp, cyc_n - su_last)
            su_last <= cyc_n;
            su_lp <= int'(su_lat[0]);
         end
      end
   end
   // cuts a hang short
   initial begin
      repeat (20000) @(posedge core_clk);
      timed_out();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {biq_valid, bu_ops_ready, bu_is_branch, bu_taken, bu_mispred} = '0;
      {bu_btb_write, bu_tight_loop, mdu_issue, mdu_ops_ready} = '0;
      {mdu_serial, mdu_oldest, mdu_is_div, ls_issue, ls_ops_ready} = '0;
      {ls_misal, misal_miss, retire_en, nrst} = '0;
      {su_issue, su_ops_ready, su_serial, oth, ls_tag, rpl_cause} = '0;
      su_lat = {6'h01, 6'h01};
      mdu_div_lat = 6'h05;
      rpl_clear = 1;
      seed = 82554;
      su_last = -1;
      repeat (12) @(negedge core_clk);
      nrst = 1;
      @(negedge core_clk);
      bu_ops_ready = 1;
      br_hold(6, ni, ns);
      `CHK("issues", 3, ni)
      `CHK("starts", 3, ns)
      biq_valid = 0;
      #1 `CHK("nothing_to_issue", 1'b1, nothing_to_issue)
      @(negedge core_clk);
      bu_ops_ready = 0;
      br_hold(4, ni, ns);
      `CHK("held_issue", 1, ni)
      #1 `CHK("station_stall", 1'b1, station_occupied_stall)
      @(negedge core_clk);
      biq_valid = 0;
      bu_ops_ready = 1;
      bu_is_branch = 1;
      repeat (3) @(negedge core_clk);
      // every redirect mode, plain and tight loop
      for (m = 0; m < 4; m++) begin
         {bu_tight_loop, bu_btb_write} = 2'(m);
         bu_mispred = 1;
         biq_valid = 1;
         #1 `CHK("mispred", 1'b1, bu_mispredict)
         @(negedge core_clk);
         {biq_valid, bu_mispred} = 2'h0;
         got = 12'h000;
         for (i = 0; i < 4; i++) begin
            #1 got = {got[8:0], fetch_redirect, btb_update, fetch_lookup_stall};
            @(negedge core_clk);
         end
         `CHK("fetch_seq", EXP_SEQ[m], got)
         repeat (4) @(negedge core_clk);
      end
      // taken branches pile up while completion holds them
      bu_taken = 1;
      br_hold(10, ni, ns);
      `CHK("taken_starts", 4, ns)
      #1 `CHK("taken_full", 1'b1, taken_branch_queue_full_stall)
      @(negedge core_clk);
      biq_valid = 0;
      retire_en = 1;
      for (i = 0; i < 20; i++) begin
         #1 if (bu_start === 1'b1) break;
         @(negedge core_clk);
      end
      if (i == 20) timed_out();
      @(negedge core_clk);
      bu_taken = 0;
      unit_run(300);
      repeat (40) @(negedge core_clk);
      // all side sources ask together with a station access waiting
      ls_ops_ready = 1;
      ls_issue = 1;
      oth = 3'h7;
      for (i = 0; i < 3; i++) begin
         #1 `CHK("src_sel", 6'h01 << i, ls_src_sel)
         @(negedge core_clk);
         oth[i] = 1'b0;
      end
      ls_go(4'h5);
      // each replay cause in turn hits a back-to-back stream
      for (m = 0; m < 7; m++) begin
         for (i = 0; i < 3; i++) ls_go(4'($random(seed)));
         ls_issue = 0;
         rpl_cause = 7'h01 << m;
         rpl_clear = 0;
         @(negedge core_clk);
         rpl_cause = 7'h00;
         repeat (3) @(negedge core_clk);
         rpl_clear = 1;
         repeat (12) @(negedge core_clk);
      end
      // misaligned access: both halves finish under one tag
      ls_misal = 1;
      ls_go(4'hA);
      {ls_misal, ls_issue} = 2'h0;
      ls_q.push_back(4'hA);
      repeat (2) @(negedge core_clk);
      #1 `CHK("mis_first", 1'b1, ls_s2_mis_first)
      repeat (4) @(negedge core_clk);
      `CHK("ls_left", 0, ls_q.size())
      results();
   end
endmodule : esc_exec_stall_tb
`undef CHK
`default_nettype wire
